// [dfra_defines.vh]
// Constants for the frequency reference auxiliary block.
// Assumes a 32-bit AHB-Lite slave; byte offsets, field positions, reset values, timing.
`ifndef DFRA_DEFINES_VH
`define DFRA_DEFINES_VH
// ****************************************
// Register byte offsets
// ****************************************
`define DFRA_CTRL 8'h00
`define DFRA_SET_FREQ 8'h04
`define DFRA_JOG_FREQ 8'h08
`define DFRA_JOG_ACC 8'h0c
`define DFRA_JOG_DEC 8'h10
`define DFRA_RAMP_BASE 8'h14
`define DFRA_SKIP1 8'h34
`define DFRA_SKIP2 8'h38
`define DFRA_SKIP_AMP 8'h3c
`define DFRA_ACC_SW 8'h40
`define DFRA_DEC_SW 8'h44
`define DFRA_DEAD 8'h48
`define DFRA_LOW_LIM 8'h4c
`define DFRA_MAX_FREQ 8'h50
`define DFRA_DROOP 8'h54
`define DFRA_PON_THR 8'h58
`define DFRA_RUN_THR 8'h5c
`define DFRA_STATUS 8'h60
`define DFRA_HOURS 8'h64
`define DFRA_IRQ_STAT 8'h68
`define DFRA_IRQ_MASK 8'h6c
// ****************************************
// Control fields
// ****************************************
`define DFRA_C_RUN 0
`define DFRA_C_REV 1
`define DFRA_C_SKIP_RAMP 2
`define DFRA_C_REV_INH 3
`define DFRA_C_LOW_MODE_LO 4
`define DFRA_C_JOG_PRIO 6
`define DFRA_C_MOTOR1 7
`define DFRA_C_FREE_STOP 8
`define DFRA_C_DI_GROUP 9
`define DFRA_C_START_MODE 10
`define DFRA_CTRL_RST 12'h080
// ****************************************
// Reset values and timing
// ****************************************
`define DFRA_JOG_FREQ_RST 16'h0258
`define DFRA_MAX_FREQ_RST 16'h1388
`define DFRA_RAMP_RST 16'h0064
`define DFRA_CLK_HZ 10000000
`define DFRA_TENTH_S_NUM 1
`define DFRA_TENTH_S_DEN 10
`define DFRA_TENTH_CYC (`DFRA_CLK_HZ * `DFRA_TENTH_S_NUM / `DFRA_TENTH_S_DEN)
`define DFRA_HOUR_S 40'h0000000e10
`define DFRA_HOUR_CYC (`DFRA_TENTH_CYC * 10 * `DFRA_HOUR_S)
`endif

// [dfra_freq_ref.v]
// Frequency reference auxiliary shaping: jog, ramp groups, skip bands, direction,
// lower limit, droop and hour thresholds, with an AHB-Lite register slave.
// Assumes one clock hclk at 10 MHz, terminals arriving asynchronously, load from hclk.
`include "dfra_defines.vh"
module dfra_freq_ref #(
  parameter TENTH_CYC = `DFRA_TENTH_CYC,
  parameter HOUR_CYC = `DFRA_HOUR_CYC
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  input wire [3:0] digital_input_terminal,
  input wire [6:0] load_pct,
  output reg [15:0] out_freq,
  output reg out_rev,
  output reg running,
  output reg do_poweron_reached,
  output reg do_run_reached,
  output reg irq
);
  // ****************************************
  // Constants and helpers
  // ****************************************
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_RUN = 2'd1;
  localparam [1:0] ST_DEAD = 2'd2;
  localparam [39:0] TENTH_W = TENTH_CYC;
  localparam [39:0] HOUR_W = HOUR_CYC;

  // Strict interior of a skip band; zero point means unused
  function in_band;
    input [15:0] f;
    input [15:0] s;
    input [15:0] a;
    begin
      in_band = (s != 16'h0000) && ({1'b0, f} + {1'b0, a} > {1'b0, s}) &&
        ({1'b0, f} < {1'b0, s} + {1'b0, a});
    end
  endfunction

  // ****************************************
  // Register file and AHB-Lite slave
  // ****************************************
  reg [11:0] ctrl_q;
  reg [15:0] set_freq_q, jog_target_freq_q, jog_accel_time_q, jog_decel_time_q;
  reg [15:0] ramp_q [0:7];
  reg [15:0] skip_freq_one_q, skip_freq_two_q, skip_band_amplitude_q;
  reg [15:0] accel_switch_point_q, decel_switch_point_q, direction_dead_time_q;
  reg [15:0] low_limit_q, max_freq_q, droop_amount_q;
  reg [15:0] poweron_hours_threshold_q, run_hours_threshold_q;
  reg [3:0] irq_stat_q, irq_mask_q;
  reg wr_pend_q;
  reg [7:0] wr_addr_q;
  reg [3:0] evt;
  reg [15:0] poweron_hours_count_q, run_hours_count_q;
  reg [15:0] cur_q;
  reg cur_rev_q;
  reg [1:0] st_q;
  integer i;

  wire addr_ok = hsel & htrans[1] & hready;
  wire [7:0] a_addr = haddr[7:0];

  // Write data phase, status W1C where a new event wins over the clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      ctrl_q <= `DFRA_CTRL_RST;
      set_freq_q <= 16'h0000;
      jog_target_freq_q <= `DFRA_JOG_FREQ_RST;
      jog_accel_time_q <= `DFRA_RAMP_RST;
      jog_decel_time_q <= `DFRA_RAMP_RST;
      for (i = 0; i < 8; i = i + 1) begin
        ramp_q[i] <= `DFRA_RAMP_RST;
      end
      skip_freq_one_q <= 16'h0000;
      skip_freq_two_q <= 16'h0000;
      skip_band_amplitude_q <= 16'h0000;
      accel_switch_point_q <= 16'h0000;
      decel_switch_point_q <= 16'h0000;
      direction_dead_time_q <= 16'h0000;
      low_limit_q <= 16'h0000;
      max_freq_q <= `DFRA_MAX_FREQ_RST;
      droop_amount_q <= 16'h0000;
      poweron_hours_threshold_q <= 16'h0000;
      run_hours_threshold_q <= 16'h0000;
      irq_stat_q <= 4'h0;
      irq_mask_q <= 4'h0;
    end else begin
      wr_pend_q <= addr_ok & hwrite;
      wr_addr_q <= a_addr;
      irq_stat_q <= irq_stat_q | evt;
      if (wr_pend_q) begin
        case (wr_addr_q)
          `DFRA_CTRL: ctrl_q <= hwdata[11:0];
          `DFRA_SET_FREQ: set_freq_q <= hwdata[15:0];
          `DFRA_JOG_FREQ: jog_target_freq_q <= hwdata[15:0];
          `DFRA_JOG_ACC: jog_accel_time_q <= hwdata[15:0];
          `DFRA_JOG_DEC: jog_decel_time_q <= hwdata[15:0];
          `DFRA_SKIP1: skip_freq_one_q <= hwdata[15:0];
          `DFRA_SKIP2: skip_freq_two_q <= hwdata[15:0];
          `DFRA_SKIP_AMP: skip_band_amplitude_q <= hwdata[15:0];
          `DFRA_ACC_SW: accel_switch_point_q <= hwdata[15:0];
          `DFRA_DEC_SW: decel_switch_point_q <= hwdata[15:0];
          `DFRA_DEAD: direction_dead_time_q <= hwdata[15:0];
          `DFRA_LOW_LIM: low_limit_q <= hwdata[15:0];
          `DFRA_MAX_FREQ: max_freq_q <= hwdata[15:0];
          `DFRA_DROOP: droop_amount_q <= hwdata[15:0];
          `DFRA_PON_THR: poweron_hours_threshold_q <= hwdata[15:0];
          `DFRA_RUN_THR: run_hours_threshold_q <= hwdata[15:0];
          `DFRA_IRQ_STAT: irq_stat_q <= (irq_stat_q & ~hwdata[3:0]) | evt;
          `DFRA_IRQ_MASK: irq_mask_q <= hwdata[3:0];
          default: begin
            if (wr_addr_q >= `DFRA_RAMP_BASE && wr_addr_q < `DFRA_SKIP1) begin
              ramp_q[wr_addr_q[4:2] - 3'd5] <= hwdata[15:0];
            end
          end
        endcase
      end
    end
  end

  // Read data captured at the address phase, zero for unmapped offsets
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h00000000;
    case (a_addr)
      `DFRA_CTRL: rd_d = {20'h00000, ctrl_q};
      `DFRA_SET_FREQ: rd_d = {16'h0000, set_freq_q};
      `DFRA_JOG_FREQ: rd_d = {16'h0000, jog_target_freq_q};
      `DFRA_JOG_ACC: rd_d = {16'h0000, jog_accel_time_q};
      `DFRA_JOG_DEC: rd_d = {16'h0000, jog_decel_time_q};
      `DFRA_SKIP1: rd_d = {16'h0000, skip_freq_one_q};
      `DFRA_SKIP2: rd_d = {16'h0000, skip_freq_two_q};
      `DFRA_SKIP_AMP: rd_d = {16'h0000, skip_band_amplitude_q};
      `DFRA_ACC_SW: rd_d = {16'h0000, accel_switch_point_q};
      `DFRA_DEC_SW: rd_d = {16'h0000, decel_switch_point_q};
      `DFRA_DEAD: rd_d = {16'h0000, direction_dead_time_q};
      `DFRA_LOW_LIM: rd_d = {16'h0000, low_limit_q};
      `DFRA_MAX_FREQ: rd_d = {16'h0000, max_freq_q};
      `DFRA_DROOP: rd_d = {16'h0000, droop_amount_q};
      `DFRA_PON_THR: rd_d = {16'h0000, poweron_hours_threshold_q};
      `DFRA_RUN_THR: rd_d = {16'h0000, run_hours_threshold_q};
      `DFRA_STATUS: rd_d = {12'h000, st_q, running, cur_rev_q, cur_q};
      `DFRA_HOURS: rd_d = {run_hours_count_q, poweron_hours_count_q};
      `DFRA_IRQ_STAT: rd_d = {28'h0000000, irq_stat_q};
      `DFRA_IRQ_MASK: rd_d = {28'h0000000, irq_mask_q};
      default: begin
        if (a_addr >= `DFRA_RAMP_BASE && a_addr < `DFRA_SKIP1) begin
          rd_d = {16'h0000, ramp_q[a_addr[4:2] - 3'd5]};
        end
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_ok && !hwrite) begin
        hrdata <= rd_d;
      end
    end
  end

  // ****************************************
  // Terminal synchronisers: 0 fwd jog, 1 rev jog, 3:2 ramp group
  // ****************************************
  reg [3:0] di_s1_q, di_s2_q, di_s3_q, di_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      di_s1_q <= 4'h0;
      di_s2_q <= 4'h0;
      di_s3_q <= 4'h0;
      di_q <= 4'h0;
    end else begin
      di_s1_q <= digital_input_terminal;
      di_s2_q <= di_s1_q;
      di_s3_q <= di_s2_q;
      di_q <= (di_s2_q & di_s3_q) | (di_q & (di_s2_q | di_s3_q));
    end
  end

  // ****************************************
  // Target selection
  // ****************************************
  wire run_cmd = ctrl_q[`DFRA_C_RUN];
  wire jog_req = di_q[0] ^ di_q[1];
  wire [1:0] low_mode = ctrl_q[`DFRA_C_LOW_MODE_LO+1:`DFRA_C_LOW_MODE_LO];
  reg jog_act_q;
  reg [15:0] tgt, sf;
  reg tgt_rev, tgt_run, rev_refused, low_stop;
  always @* begin
    sf = (set_freq_q > max_freq_q) ? max_freq_q : set_freq_q;
    low_stop = 1'b0;
    if (sf < low_limit_q) begin
      case (low_mode)
        2'd0: sf = low_limit_q;
        2'd1: begin
          sf = 16'h0000;
          low_stop = 1'b1;
        end
        default: sf = 16'h0000;
      endcase
    end
    // Skip band holds the nearer edge
    if (in_band(sf, skip_freq_one_q, skip_band_amplitude_q)) begin
      sf = (sf < skip_freq_one_q) ? skip_freq_one_q - skip_band_amplitude_q :
        skip_freq_one_q + skip_band_amplitude_q;
    end else if (in_band(sf, skip_freq_two_q, skip_band_amplitude_q)) begin
      sf = (sf < skip_freq_two_q) ? skip_freq_two_q - skip_band_amplitude_q :
        skip_freq_two_q + skip_band_amplitude_q;
    end
    if (jog_act_q) begin
      tgt = jog_target_freq_q;
      tgt_rev = di_q[1];
      tgt_run = 1'b1;
    end else begin
      tgt = sf;
      tgt_rev = ctrl_q[`DFRA_C_REV];
      tgt_run = run_cmd & ~low_stop;
    end
    rev_refused = tgt_rev & ctrl_q[`DFRA_C_REV_INH] & tgt_run;
    if (rev_refused) begin
      tgt_run = 1'b0;
    end
    if (!tgt_run) begin
      tgt = 16'h0000;
    end
  end

  // Jog admission: idle or no run command always, running under a run command only with priority
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      jog_act_q <= 1'b0;
    end else if (!jog_req) begin
      jog_act_q <= 1'b0;
    end else if (!run_cmd || ctrl_q[`DFRA_C_JOG_PRIO] || st_q == ST_IDLE) begin
      jog_act_q <= 1'b1;
    end
  end

  // A run begun by jog keeps jog ramps and ramp stop until idle or a run command
  reg jog_run_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      jog_run_q <= 1'b0;
    end else if (jog_act_q) begin
      jog_run_q <= 1'b1;
    end else if (st_q == ST_IDLE || tgt_run) begin
      jog_run_q <= 1'b0;
    end
  end

  // ****************************************
  // Ramp time selection
  // ****************************************
  wire need_zero = (tgt_rev != cur_rev_q) && cur_q != 16'h0000;
  wire up = !need_zero && tgt > cur_q;
  reg [15:0] rtime;
  reg [1:0] grp;
  always @* begin
    if (ctrl_q[`DFRA_C_DI_GROUP]) begin
      grp = di_q[3:2];
    end else if (ctrl_q[`DFRA_C_MOTOR1]) begin
      grp = up ? {1'b0, cur_q >= accel_switch_point_q} :
        {1'b0, cur_q <= decel_switch_point_q};
    end else begin
      grp = 2'd0;
    end
    if (jog_act_q || jog_run_q) begin
      rtime = up ? jog_accel_time_q : jog_decel_time_q;
    end else begin
      rtime = ramp_q[{grp, ~up}];
    end
  end

  // ****************************************
  // Ramp generator and direction dead time
  // ****************************************
  reg [39:0] racc_q, dead_cnt_q;
  reg [15:0] dead_tenths_q;
  wire [39:0] rthr = rtime * TENTH_W;
  wire [39:0] racc_n = racc_q + {24'h000000, max_freq_q};
  wire step_ok = (rtime == 16'h0000) || (racc_n >= rthr);
  wire free_stop = ctrl_q[`DFRA_C_FREE_STOP] && !jog_act_q && !jog_run_q && !tgt_run;
  reg [15:0] nxt;
  always @* begin
    nxt = up ? cur_q + 16'h0001 : cur_q - 16'h0001;
    if (ctrl_q[`DFRA_C_SKIP_RAMP]) begin
      if (in_band(nxt, skip_freq_one_q, skip_band_amplitude_q)) begin
        nxt = up ? skip_freq_one_q + skip_band_amplitude_q :
          skip_freq_one_q - skip_band_amplitude_q;
      end else if (in_band(nxt, skip_freq_two_q, skip_band_amplitude_q)) begin
        nxt = up ? skip_freq_two_q + skip_band_amplitude_q :
          skip_freq_two_q - skip_band_amplitude_q;
      end
    end
    if (rtime == 16'h0000) begin
      nxt = need_zero ? 16'h0000 : tgt;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= ST_IDLE;
      cur_q <= 16'h0000;
      cur_rev_q <= 1'b0;
      racc_q <= 40'h0000000000;
      dead_cnt_q <= 40'h0000000000;
      dead_tenths_q <= 16'h0000;
    end else begin
      case (st_q)
        ST_IDLE: begin
          racc_q <= 40'h0000000000;
          if (tgt_run && tgt != 16'h0000) begin
            st_q <= ST_RUN; // Direct start; startup mode is not applied
            cur_rev_q <= tgt_rev;
          end
        end
        ST_RUN: begin
          if (free_stop) begin
            cur_q <= 16'h0000;
            st_q <= ST_IDLE;
          end else if (cur_q == 16'h0000 && !tgt_run) begin
            st_q <= ST_IDLE;
          end else if (cur_q == 16'h0000 && tgt_rev != cur_rev_q) begin
            st_q <= ST_DEAD;
            dead_cnt_q <= 40'h0000000000;
            dead_tenths_q <= 16'h0000;
          end else if (cur_q != tgt || need_zero) begin
            if (step_ok) begin
              cur_q <= nxt;
              racc_q <= (rtime == 16'h0000) ? 40'h0000000000 : racc_n - rthr;
            end else begin
              racc_q <= racc_n;
            end
          end else begin
            racc_q <= 40'h0000000000;
          end
        end
        ST_DEAD: begin
          // Output held at 0 Hz while counting tenths of a second
          if (!tgt_run) begin
            st_q <= ST_IDLE;
          end else if (dead_tenths_q >= direction_dead_time_q) begin
            cur_rev_q <= tgt_rev;
            st_q <= ST_RUN;
          end else if (dead_cnt_q == TENTH_W - 40'h0000000001) begin
            dead_cnt_q <= 40'h0000000000;
            dead_tenths_q <= dead_tenths_q + 16'h0001;
          end else begin
            dead_cnt_q <= dead_cnt_q + 40'h0000000001;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Droop and outputs
  // ****************************************
  wire [22:0] droop_prod = droop_amount_q * load_pct;
  wire [22:0] droop_quot = droop_prod / 23'd100;
  wire [15:0] droop_hz = droop_quot[15:0];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_freq <= 16'h0000;
      out_rev <= 1'b0;
      running <= 1'b0;
    end else begin
      out_freq <= (cur_q > droop_hz) ? cur_q - droop_hz : 16'h0000;
      out_rev <= cur_rev_q;
      running <= (st_q != ST_IDLE);
    end
  end

  // ****************************************
  // Hour counters, thresholds and interrupt
  // ****************************************
  reg [39:0] pon_cyc_q, run_cyc_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pon_cyc_q <= 40'h0000000000;
      run_cyc_q <= 40'h0000000000;
      poweron_hours_count_q <= 16'h0000;
      run_hours_count_q <= 16'h0000;
      do_poweron_reached <= 1'b0;
      do_run_reached <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (pon_cyc_q == HOUR_W - 40'h0000000001) begin
        pon_cyc_q <= 40'h0000000000;
        if (poweron_hours_count_q != 16'hffff) begin
          poweron_hours_count_q <= poweron_hours_count_q + 16'h0001;
        end
      end else begin
        pon_cyc_q <= pon_cyc_q + 40'h0000000001;
      end
      if (st_q != ST_IDLE) begin
        if (run_cyc_q == HOUR_W - 40'h0000000001) begin
          run_cyc_q <= 40'h0000000000;
          if (run_hours_count_q != 16'hffff) begin
            run_hours_count_q <= run_hours_count_q + 16'h0001;
          end
        end else begin
          run_cyc_q <= run_cyc_q + 40'h0000000001;
        end
      end
      do_poweron_reached <= poweron_hours_count_q >= poweron_hours_threshold_q;
      do_run_reached <= run_hours_count_q >= run_hours_threshold_q;
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Events: hour thresholds rising, reverse refused, stop below limit
  reg rev_ref_q, low_stop_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rev_ref_q <= 1'b0;
      low_stop_q <= 1'b0;
    end else begin
      rev_ref_q <= rev_refused;
      low_stop_q <= low_stop & run_cmd;
    end
  end
  always @* begin
    evt[0] = (poweron_hours_count_q >= poweron_hours_threshold_q) & ~do_poweron_reached;
    evt[1] = (run_hours_count_q >= run_hours_threshold_q) & ~do_run_reached;
    evt[2] = rev_refused & ~rev_ref_q;
    evt[3] = low_stop & run_cmd & ~low_stop_q;
  end
endmodule // dfra_freq_ref

// [dfra_term_model.sv]
// Terminal side model: digital input terminals and the motor load seen by the block.
// Assumes the bench changes its commands right after a rising edge of hclk.
// ****************************************
// Terminal and load model
// ****************************************
module dfra_term_model (
  input wire hclk,
  input wire [3:0] di_cmd,
  input wire [6:0] load_cmd,
  output logic [3:0] digital_input_terminal,
  output logic [6:0] load_pct
);
  timeunit 1ns;
  timeprecision 1ns;
  // Quiet terminals and no load from time zero
  initial begin
    digital_input_terminal = 4'h0;
    load_pct = 7'h00;
  end
  // Terminals move on an edge; load is clamped to the sensor range of 0..100 percent
  always @(posedge hclk) begin
    digital_input_terminal <= di_cmd;
    load_pct <= (load_cmd > 7'h64) ? 7'h64 : load_cmd;
  end
endmodule // dfra_term_model

// [dfra_freq_ref_chk.sv]
// Checker for dfra_freq_ref: bus replies, read data, direction change, stop and interrupt.
// Assumes a bind into dfra_freq_ref and the single clock domain hclk.
module dfra_freq_ref_chk (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire [15:0] out_freq,
  input wire out_rev,
  input wire running,
  input wire irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Shadow of control and mask registers
  // ****************************************
  logic wr_q;
  logic [7:0] adr_q;
  logic [10:0] ctrl_q;
  logic [3:0] mask_q;
  wire take = hsel && htrans[1] && hreadyout;
  wire rd_low = take && !hwrite && haddr[31:8] == 24'h0;
  wire [10:0] ctrl_d = (wr_q && adr_q == 8'h00) ? hwdata[10:0] : ctrl_q;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Write data lands one edge after its address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      adr_q <= 8'h00;
      ctrl_q <= 11'h080;
      mask_q <= 4'h0;
    end else begin
      wr_q <= take && hwrite;
      adr_q <= haddr[7:0];
      ctrl_q <= ctrl_d;
      if (wr_q && adr_q == 8'h6c)
        mask_q <= hwdata[3:0];
    end
  end
  property p_ready; hreadyout && !hresp; endproperty
  a_ready: assert property (p_ready) else $error("slave not ready or not okay");
  property p_hold; !$past(take && !hwrite) |-> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  property p_unmap; rd_low && haddr[7:0] >= 8'h70 |=> hrdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_ctrl_rb;
    rd_low && haddr[7:0] == 8'h00 |=> hrdata == {21'h0, $past(ctrl_q)};
  endproperty
  a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback wrong");
  property p_idle; (!running) [*3] |-> out_freq == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("frequency while idle");
  property p_rev_inh; ctrl_q[3] && !out_rev |=> !out_rev; endproperty
  a_rev_inh: assert property (p_rev_inh) else $error("reverse while inhibited");
  property p_dead;
    $changed(out_rev) |-> out_freq == 16'h0000 && $past(out_freq) == 16'h0000;
  endproperty
  a_dead: assert property (p_dead) else $error("direction flip not at zero");
  property p_mask; mask_q == 4'h0 |=> !irq; endproperty
  a_mask: assert property (p_mask) else $error("interrupt with all masked");
endmodule // dfra_freq_ref_chk
bind dfra_freq_ref dfra_freq_ref_chk i_dfra_freq_ref_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .out_freq(out_freq), .out_rev(out_rev), .running(running), .irq(irq)
);

// [test_dfra_freq_ref.sv]
// Bench for dfra_freq_ref: jog, skip bands, ramp groups, limits, direction and hours.
// Assumes shortened tenth-second and hour counts and the terminal model beside the block.
`include "dfra_defines.vh"
module test_dfra_freq_ref;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic watch = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] di = 4'h0;
  logic [6:0] load = 7'h00;
  logic [31:0] r;
  logic [31:0] hrs;
  logic [1:0] mode_tab [3] = '{2'h0, 2'h2, 2'h1};
  logic [15:0] lim_tab [3] = '{16'h01f4, 16'h0000, 16'h0000};
  logic run_tab [3] = '{1'b1, 1'b1, 1'b0};
  wire hready, hresp, out_rev, running, pon_hit, run_hit, irq;
  wire [31:0] hrdata;
  wire [15:0] out_freq;
  wire [3:0] dit;
  wire [6:0] lpct;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  int inband = 0;
  int n;
  dfra_freq_ref #(.TENTH_CYC(4), .HOUR_CYC(100)) i_dfra_freq_ref (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .digital_input_terminal(dit), .load_pct(lpct),
    .out_freq(out_freq), .out_rev(out_rev), .running(running),
    .do_poweron_reached(pon_hit), .do_run_reached(run_hit), .irq(irq));
  dfra_term_model i_dfra_term_model (.hclk(hclk), .di_cmd(di), .load_cmd(load),
    .digital_input_terminal(dit), .load_pct(lpct));
  // ****************************************
  // Clock, watchdog and helpers
  // ****************************************
  always #50 hclk = ~hclk;
  // Cuts a hang short
  always @(posedge hclk) begin
    cyc++;
    if (cyc > 60000) begin
      err_total++;
      summarize();
    end
  end
  // Counts cycles spent strictly inside the skip band while watched
  always @(negedge hclk)
    if (watch && out_freq > 16'h0384 && out_freq < 16'h044c)
      inband++;
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t saw %h want %h", $time, seen, exp);
    end
  endtask
  // One single word transfer; read data lands in r
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  // Waits for a frequency, n holds the cycles taken
  task automatic wait_f(input logic [15:0] e);
    n = 0;
    @(negedge hclk);
    while (out_freq !== e && n < 4000) begin
      @(negedge hclk);
      n++;
    end
    chk(out_freq, e);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, `DFRA_CTRL, 32'h0);
    chk(r, 32'h080);
    xfer(1'b0, `DFRA_JOG_FREQ, 32'h0);
    chk(r, 32'h258);
    xfer(1'b0, 8'h80, 32'h0);
    chk(r, 32'h0);
    xfer(1'b1, `DFRA_JOG_ACC, 32'h1);
    xfer(1'b1, `DFRA_JOG_DEC, 32'h1);
    xfer(1'b1, `DFRA_CTRL, 32'h580);
    di <= 4'h1;
    wait_f(16'h0258);
    @(posedge hclk);
    di <= 4'h0;
    repeat (20) @(negedge hclk);
    chk(out_freq > 16'h0 && out_freq < 16'h0258, 1'b1);
    wait_f(16'h0);
    for (int k = 0; k < 8; k++)
      xfer(1'b1, `DFRA_RAMP_BASE + 8'h04 * k[7:0], 32'h0);
    xfer(1'b1, `DFRA_SKIP1, 32'h3e8);
    xfer(1'b1, `DFRA_SKIP_AMP, 32'h64);
    xfer(1'b1, `DFRA_SET_FREQ, 32'h41a);
    xfer(1'b1, `DFRA_CTRL, 32'h081);
    wait_f(16'h044c);
    xfer(1'b1, `DFRA_SET_FREQ, 32'h3c0);
    wait_f(16'h0384);
    xfer(1'b1, `DFRA_RAMP_BASE + 8'h08, 32'h64);
    xfer(1'b1, `DFRA_CTRL, 32'h085);
    watch = 1'b1;
    xfer(1'b1, `DFRA_SET_FREQ, 32'h5dc);
    wait_f(16'h05dc);
    watch = 1'b0;
    chk(inband, 32'h0);
    xfer(1'b1, `DFRA_RAMP_BASE + 8'h08, 32'h0);
    xfer(1'b1, `DFRA_CTRL, 32'h081);
    xfer(1'b1, `DFRA_SKIP1, 32'h0);
    xfer(1'b1, `DFRA_SET_FREQ, 32'h3c0);
    wait_f(16'h03c0);
    xfer(1'b1, `DFRA_DROOP, 32'h64);
    load <= 7'h32;
    wait_f(16'h038e);
    load <= 7'h00;
    xfer(1'b1, `DFRA_ACC_SW, 32'h7d0);
    xfer(1'b1, `DFRA_DEC_SW, 32'h7d0);
    xfer(1'b1, `DFRA_RAMP_BASE, 32'h64);
    xfer(1'b1, `DFRA_RAMP_BASE + 8'h04, 32'h64);
    xfer(1'b1, `DFRA_SET_FREQ, 32'hbb8);
    wait_f(16'h0bb8);
    chk(n > 900 && n < 1200, 1'b1);
    xfer(1'b1, `DFRA_SET_FREQ, 32'h3c0);
    wait_f(16'h03c0);
    chk(n > 900 && n < 1200, 1'b1);
    di <= 4'hc;
    xfer(1'b1, `DFRA_CTRL, 32'h281);
    xfer(1'b1, `DFRA_SET_FREQ, 32'hbb8);
    wait_f(16'h0bb8);
    chk(n < 12, 1'b1);
    @(posedge hclk);
    di <= 4'hd;
    repeat (40) @(negedge hclk);
    chk(out_freq, 16'h0bb8);
    xfer(1'b1, `DFRA_CTRL, 32'h2c1);
    wait_f(16'h0258);
    xfer(1'b1, `DFRA_CTRL, 32'h2c0);
    di <= 4'hc;
    wait_f(16'h0);
    xfer(1'b1, `DFRA_LOW_LIM, 32'h1f4);
    xfer(1'b1, `DFRA_SET_FREQ, 32'h12c);
    for (int m = 0; m < 3; m++) begin
      xfer(1'b1, `DFRA_CTRL, 32'h281 | {26'h0, mode_tab[m], 4'h0});
      wait_f(lim_tab[m]);
      repeat (4) @(negedge hclk);
      chk(running, run_tab[m]);
    end
    xfer(1'b1, `DFRA_CTRL, 32'h280);
    xfer(1'b0, `DFRA_IRQ_STAT, 32'h0);
    chk(r[3], 1'b1);
    xfer(1'b1, `DFRA_IRQ_MASK, 32'h8);
    repeat (3) @(negedge hclk);
    chk(irq, 1'b1);
    xfer(1'b1, `DFRA_IRQ_STAT, 32'h8);
    repeat (3) @(negedge hclk);
    chk(irq, 1'b0);
    xfer(1'b1, `DFRA_LOW_LIM, 32'h0);
    xfer(1'b1, `DFRA_SET_FREQ, 32'h3e8);
    xfer(1'b1, `DFRA_CTRL, 32'h28b);
    repeat (40) @(negedge hclk);
    chk(out_rev, 1'b0);
    chk(irq, 1'b0);
    xfer(1'b0, `DFRA_IRQ_STAT, 32'h0);
    chk(r[2], 1'b1);
    xfer(1'b1, `DFRA_DEAD, 32'h2);
    xfer(1'b1, `DFRA_CTRL, 32'h281);
    wait_f(16'h03e8);
    xfer(1'b1, `DFRA_CTRL, 32'h283);
    wait_f(16'h0);
    wait_f(16'h03e8);
    chk(n > 5 && n < 15, 1'b1);
    chk(out_rev, 1'b1);
    xfer(1'b1, `DFRA_CTRL, 32'h280);
    xfer(1'b0, `DFRA_HOURS, 32'h0);
    hrs = r;
    xfer(1'b1, `DFRA_PON_THR, {16'h0, hrs[15:0] + 16'h3});
    xfer(1'b1, `DFRA_RUN_THR, {16'h0, hrs[31:16] + 16'h1});
    repeat (3) @(negedge hclk);
    chk(pon_hit, 1'b0);
    repeat (350) @(negedge hclk);
    chk(pon_hit, 1'b1);
    chk(run_hit, 1'b0);
    xfer(1'b1, `DFRA_CTRL, 32'h281);
    repeat (150) @(negedge hclk);
    chk(run_hit, 1'b1);
    summarize();
  end
endmodule // test_dfra_freq_ref
